// ==== design/rsg_top.sv ====
// receiver peak signal-strength and gain-reduction status registers
//
// Contract
// - AM peak strength code in bits 7..4
// - PM peak strength code in bits 3..0
// - peaks clear at message start, clear command
// - monotonic code, 0 at or below floor
// - both registers zero at reset, set-default
// - channel select picks internally used peak
// - AM second-stage gain cut in bits 7..4
// - PM second-stage gain cut in bits 3..0
// - gain cut sums config, squelch and agc
`timescale 1ns/100ps
`default_nettype none
`include "rsg_consts.svh"

module rsg_top
(
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [`RSG_ADDR_W-1:0] reg_addr,
  input wire logic [`RSG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`RSG_DATA_W-1:0] reg_rdata,
  // comparator ladders of the receive channels, asynchronous
  input wire logic [`RSG_THERMO_W-1:0] am_level_thermo,
  input wire logic [`RSG_THERMO_W-1:0] pm_level_thermo,
  // events from the framing and command logic
  input wire logic msg_start,
  input wire logic clear_strength_cmd,
  input wire logic set_default_cmd,
  input wire logic chan_select,
  // gain contributions, AM in the upper nibble
  input wire logic [`RSG_DATA_W-1:0] cfg_gain_cut,
  input wire logic [`RSG_DATA_W-1:0] squelch_gain_cut,
  input wire logic [`RSG_DATA_W-1:0] agc_gain_cut,
  // views for the rest of the receiver
  output logic [`RSG_DATA_W-1:0] peak_strength,
  output logic [`RSG_DATA_W-1:0] gain_cut,
  output logic [`RSG_CODE_W-1:0] sel_strength
);

  // ===========================================================================
  // state
  rsg_pkg::rsg_state_t state_q;
  rsg_pkg::rsg_state_t state_d;

  // reset images held as sized constants so their nibbles can be sliced
  localparam logic [`RSG_DATA_W-1:0] peak_rst_val = `RSG_PEAK_STRENGTH_RST;
  localparam logic [`RSG_DATA_W-1:0] gain_rst_val = `RSG_GAIN_CUT_RST;

  // per-channel combinational results
  rsg_pkg::rsg_code_t [`RSG_CHANNELS-1:0] code_now;
  rsg_pkg::rsg_code_t [`RSG_CHANNELS-1:0] gain_now;
  rsg_pkg::rsg_thermo_t [`RSG_CHANNELS-1:0] thermo_in;

  // ===========================================================================
  // helpers
  // highest tripped comparator gives the code; a bubble in the ladder
  // cannot make the code go down, so the code stays monotonic
  function automatic rsg_pkg::rsg_code_t rsg_encode(input rsg_pkg::rsg_thermo_t th);
    rsg_pkg::rsg_code_t code;
    code = `RSG_CODE_ZERO; // no comparator tripped, at or below floor
    for (int k = 0; k < `RSG_THERMO_W; k++)
    begin
      if (th[k])
      begin
        code = `RSG_CODE_W'(k + 1); // top comparator gives 14
      end
    end
    return code;
  endfunction : rsg_encode

  // true when the code beats the stored peak
  function automatic logic rsg_beats(input rsg_pkg::rsg_code_t now,
                                     input rsg_pkg::rsg_code_t held);
    logic win;
    win = (now > held);
    return win;
  endfunction : rsg_beats

  // ===========================================================================
  // channel inputs gathered by index
  assign thermo_in[`RSG_CH_AM] = am_level_thermo;
  assign thermo_in[`RSG_CH_PM] = pm_level_thermo;

  // ===========================================================================
  // per-channel encoder and gain adder
  genvar ch;
  generate
    for (ch = 0; ch < `RSG_CHANNELS; ch++)
    begin : g_chan
      rsg_gain_if gif();

      // contributions come from logic on this clock, no synchroniser
      assign gif.cfg = cfg_gain_cut[ch*`RSG_CODE_W +: `RSG_CODE_W];
      assign gif.squelch = squelch_gain_cut[ch*`RSG_CODE_W +: `RSG_CODE_W];
      assign gif.agc = agc_gain_cut[ch*`RSG_CODE_W +: `RSG_CODE_W];

      rsg_gain_sum u_sum
      (
        .gi (gif.adder)
      );

      // total of config, squelch and agc reduction
      assign gain_now[ch] = gif.total;

      // encode only the filtered ladder, never a raw stage
      assign code_now[ch] = rsg_encode(state_q.level[ch]);
    end
  endgenerate

  // ===========================================================================
  // next state
  always_comb
  begin
    state_d = state_q;

    // ladder synchroniser: stage 0 feeds stage 1 only
    for (int c = 0; c < `RSG_CHANNELS; c++)
    begin
      state_d.sync[c][0] = thermo_in[c];
      state_d.sync[c][1] = state_q.sync[c][0];
      state_d.sync[c][2] = state_q.sync[c][1];
      // take a change once the last two stages agree, so a ladder caught
      // mid-transition never produces a phantom peak
      if (state_q.sync[c][1] == state_q.sync[c][2])
      begin
        state_d.level[c] = state_q.sync[c][2];
      end
    end

    // peak tracking per channel
    for (int c = 0; c < `RSG_CHANNELS; c++)
    begin
      if (rsg_beats(code_now[c], state_q.peak[c]))
      begin
        state_d.peak[c] = code_now[c]; // AM and PM peaks
      end
    end

    // clears win over a rising sample in the same cycle; the next cycle
    // starts the new peak from the live code
    if (msg_start || clear_strength_cmd)
    begin
      state_d.peak[`RSG_CH_AM] = `RSG_CODE_ZERO;
      state_d.peak[`RSG_CH_PM] = `RSG_CODE_ZERO;
    end

    // applied gain cut follows the adders every cycle without set_default_cmd
    for (int c = 0; c < `RSG_CHANNELS; c++)
    begin
      state_d.gain[c] = gain_now[c]; // AM and PM gain cut
    end

    // restore defaults zeroes both status registers for one cycle
    if (set_default_cmd)
    begin
      state_d.peak[`RSG_CH_AM] = peak_rst_val[`RSG_AM_STRENGTH_BIT3:`RSG_AM_STRENGTH_BIT0];
      state_d.peak[`RSG_CH_PM] = peak_rst_val[`RSG_PM_STRENGTH_BIT3:`RSG_PM_STRENGTH_BIT0];
      state_d.gain[`RSG_CH_AM] = gain_rst_val[`RSG_AM_GAIN_CUT_BIT3:`RSG_AM_GAIN_CUT_BIT0];
      state_d.gain[`RSG_CH_PM] = gain_rst_val[`RSG_PM_GAIN_CUT_BIT3:`RSG_PM_GAIN_CUT_BIT0];
    end

    // internal consumers see only the selected channel's peak
    if (chan_select)
    begin
      state_d.sel = state_q.peak[`RSG_CH_PM]; // select high means PM
    end
    else
    begin
      state_d.sel = state_q.peak[`RSG_CH_AM]; // select low means AM
    end

    // read data stands for the one cycle after the strobe only
    state_d.rdata = `RSG_UNMAPPED_DATA;
    if (reg_rd)
    begin
      case (reg_addr)
        `RSG_OFS_PEAK_STRENGTH:
        begin
          state_d.rdata[`RSG_AM_STRENGTH_BIT3:`RSG_AM_STRENGTH_BIT0] = state_q.peak[`RSG_CH_AM];
          state_d.rdata[`RSG_PM_STRENGTH_BIT3:`RSG_PM_STRENGTH_BIT0] = state_q.peak[`RSG_CH_PM];
        end
        `RSG_OFS_GAIN_CUT:
        begin
          state_d.rdata[`RSG_AM_GAIN_CUT_BIT3:`RSG_AM_GAIN_CUT_BIT0] = state_q.gain[`RSG_CH_AM];
          state_d.rdata[`RSG_PM_GAIN_CUT_BIT3:`RSG_PM_GAIN_CUT_BIT0] = state_q.gain[`RSG_CH_PM];
        end
        default:
        begin
          state_d.rdata = `RSG_UNMAPPED_DATA; // unmapped reads as zero
        end
      endcase
    end

    // writes carry no effect: reg_wr and reg_wdata are deliberately
    // left out of every term above, so no write can disturb the fields
    // and a read changes nothing but the read data
  end

  // ===========================================================================
  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= '0; // all fields zero from power-up
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ===========================================================================
  // outputs, straight from the state register
  assign reg_rdata = state_q.rdata;
  assign peak_strength = {state_q.peak[`RSG_CH_AM], state_q.peak[`RSG_CH_PM]};
  assign gain_cut = {state_q.gain[`RSG_CH_AM], state_q.gain[`RSG_CH_PM]};
  assign sel_strength = state_q.sel;

  // unused write data kept visible for lint, read-only block
  logic unused_wr;
  assign unused_wr = reg_wr ^ (^reg_wdata);

endmodule : rsg_top

`default_nettype wire

// ==== design/rsg_consts.svh ====
// constants of the receiver signal-strength and gain-reduction status block
`ifndef RSG_CONSTS_SVH
`define RSG_CONSTS_SVH

// ===========================================================================
// widths
`define RSG_ADDR_W 8
`define RSG_DATA_W 8
`define RSG_CODE_W 4
`define RSG_THERMO_W 14
`define RSG_SYNC_STAGES 3
`define RSG_CHANNELS 2
`define RSG_SUM_W 6

// ===========================================================================
// channel index; the index times the code width is the nibble position
`define RSG_CH_PM 0
`define RSG_CH_AM 1

// ===========================================================================
// register offsets and reset values
`define RSG_OFS_PEAK_STRENGTH 8'h2C
`define RSG_OFS_GAIN_CUT 8'h2D
`define RSG_PEAK_STRENGTH_RST 8'h00
`define RSG_GAIN_CUT_RST 8'h00
`define RSG_UNMAPPED_DATA 8'h00
`define RSG_CODE_ZERO 4'h0
`define RSG_CODE_MAX 4'hF

// ===========================================================================
// field positions
`define RSG_AM_STRENGTH_BIT3 7
`define RSG_AM_STRENGTH_BIT0 4
`define RSG_PM_STRENGTH_BIT3 3
`define RSG_PM_STRENGTH_BIT0 0
`define RSG_AM_GAIN_CUT_BIT3 7
`define RSG_AM_GAIN_CUT_BIT0 4
`define RSG_PM_GAIN_CUT_BIT3 3
`define RSG_PM_GAIN_CUT_BIT0 0

`endif

// ==== design/rsg_pkg.sv ====
// types of the receiver signal-strength and gain-reduction status block
`include "rsg_consts.svh"

package rsg_pkg;

  // ===========================================================================
  // basic types
  typedef logic [`RSG_CODE_W-1:0] rsg_code_t;
  typedef logic [`RSG_THERMO_W-1:0] rsg_thermo_t;

  // ===========================================================================
  // whole state of the top module
  typedef struct packed {
    rsg_thermo_t [`RSG_CHANNELS-1:0][`RSG_SYNC_STAGES-1:0] sync;
    rsg_thermo_t [`RSG_CHANNELS-1:0] level;
    rsg_code_t [`RSG_CHANNELS-1:0] peak;
    rsg_code_t [`RSG_CHANNELS-1:0] gain;
    logic [`RSG_DATA_W-1:0] rdata;
    rsg_code_t sel;
  } rsg_state_t;

endpackage : rsg_pkg

// ==== design/rsg_gain_if.sv ====
// carrier between the top and the per-channel gain adder
`timescale 1ns/100ps
`default_nettype none

interface rsg_gain_if;
  rsg_pkg::rsg_code_t cfg;
  rsg_pkg::rsg_code_t squelch;
  rsg_pkg::rsg_code_t agc;
  rsg_pkg::rsg_code_t total;

  modport src (output cfg, output squelch, output agc, input total);
  modport adder (input cfg, input squelch, input agc, output total);
endinterface : rsg_gain_if

`default_nettype wire

// ==== design/rsg_gain_sum.sv ====
// saturating sum of the three gain-reduction contributions of one channel
`timescale 1ns/100ps
`default_nettype none
`include "rsg_consts.svh"

module rsg_gain_sum
(
  rsg_gain_if.adder gi
);

  logic [`RSG_SUM_W-1:0] raw;

  // ===========================================================================
  // combined reduction, clipped so a large squelch plus agc cannot wrap
  always_comb
  begin
    raw = {2'h0, gi.cfg} + {2'h0, gi.squelch} + {2'h0, gi.agc};
    if (raw > {2'h0, `RSG_CODE_MAX})
    begin
      gi.total = `RSG_CODE_MAX;
    end
    else
    begin
      gi.total = raw[`RSG_CODE_W-1:0];
    end
  end

endmodule : rsg_gain_sum

`default_nettype wire

// ==== test/rsg_properties.sv ====
// concurrent checks on the status block's ports
`timescale 1ns/100ps
`default_nettype none
`include "rsg_consts.svh"

module rsg_properties
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`RSG_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [`RSG_DATA_W-1:0] reg_rdata,
  input wire logic msg_start,
  input wire logic clear_strength_cmd,
  input wire logic set_default_cmd,
  input wire logic chan_select,
  input wire logic [`RSG_DATA_W-1:0] cfg_gain_cut,
  input wire logic [`RSG_DATA_W-1:0] squelch_gain_cut,
  input wire logic [`RSG_DATA_W-1:0] agc_gain_cut,
  input wire logic [`RSG_DATA_W-1:0] peak_strength,
  input wire logic [`RSG_DATA_W-1:0] gain_cut,
  input wire logic [`RSG_CODE_W-1:0] sel_strength
);
  // saturating sum, wide enough that three nibbles never wrap
  function automatic logic [3:0] sat3(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
    logic [5:0] s;
    s = 6'(a) + 6'(b) + 6'(c);
    return (s > 6'h0F) ? 4'hF : s[3:0];
  endfunction : sat3

  // ===========================================================================
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rd_peak;
    reg_rd && reg_addr == 8'h2C |=> reg_rdata == $past(peak_strength);
  endproperty
  a_rd_peak: assert property (p_rd_peak) else $error("peak read data wrong");
  property p_rd_gain;
    reg_rd && reg_addr == 8'h2D |=> reg_rdata == $past(gain_cut);
  endproperty
  a_rd_gain: assert property (p_rd_gain) else $error("gain read data wrong");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_clear;
    msg_start || clear_strength_cmd |=> peak_strength == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("peaks not cleared");
  property p_default;
    set_default_cmd |=> peak_strength == 8'h00 && gain_cut == 8'h00;
  endproperty
  a_default: assert property (p_default) else $error("defaults not restored");
  // both nibbles follow the sum of the previous cycle's contributions
  property p_gain_sum;
    !set_default_cmd |=> gain_cut == {sat3($past(cfg_gain_cut[7:4]), $past(squelch_gain_cut[7:4]),
      $past(agc_gain_cut[7:4])), sat3($past(cfg_gain_cut[3:0]), $past(squelch_gain_cut[3:0]),
      $past(agc_gain_cut[3:0]))};
  endproperty
  a_gain_sum: assert property (p_gain_sum) else $error("gain total wrong");
  property p_peak_hold;
    !(msg_start || clear_strength_cmd || set_default_cmd) |=>
      peak_strength[7:4] >= $past(peak_strength[7:4]) && peak_strength[3:0] >= $past(peak_strength[3:0]);
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("peak dropped");
  property p_code_range;
    peak_strength[7:4] != 4'hF && peak_strength[3:0] != 4'hF;
  endproperty
  a_code_range: assert property (p_code_range) else $error("code 15 produced");
  property p_sel;
    !set_default_cmd |=> sel_strength == ($past(chan_select) ? $past(peak_strength[3:0]) : $past(peak_strength[7:4]));
  endproperty
  a_sel: assert property (p_sel) else $error("selected peak wrong");

  // main scenarios seen
  c_rd: cover property (reg_rd && reg_addr == 8'h2C && peak_strength != 8'h00);
  c_clr: cover property (clear_strength_cmd && peak_strength != 8'h00);
  c_msg: cover property (msg_start && peak_strength != 8'h00);
endmodule : rsg_properties

bind rsg_top rsg_properties u_rsg_properties (.sys_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .msg_start,
  .clear_strength_cmd, .set_default_cmd, .chan_select, .cfg_gain_cut, .squelch_gain_cut, .agc_gain_cut,
  .peak_strength, .gain_cut, .sel_strength);

`default_nettype wire

// ==== test/rsg_host.sv ====
// host model reading the status registers over the plain port
`timescale 1ns/100ps
`default_nettype none

module rsg_host
(
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // idle bus from time zero
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  end

  // one-cycle read; data taken mid-cycle after the strobe edge to avoid races
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  // one-cycle write
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr
endmodule : rsg_host

`default_nettype wire

// ==== test/rsg_top_test.sv ====
// self-checking testbench of the status block
`timescale 1ns/100ps
`default_nettype none

module rsg_top_test;
  logic sys_clk, rst, msg_start, clear_strength_cmd, set_default_cmd, chan_select;
  logic [13:0] am_level_thermo, pm_level_thermo;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg_gain_cut, squelch_gain_cut, agc_gain_cut;
  logic [7:0] peak_strength, gain_cut, rd_val;
  logic reg_wr, reg_rd;
  logic [3:0] sel_strength;
  int n_fail, checks;

  rsg_top u_rsg_top (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .am_level_thermo,
    .pm_level_thermo, .msg_start, .clear_strength_cmd, .set_default_cmd, .chan_select, .cfg_gain_cut,
    .squelch_gain_cut, .agc_gain_cut, .peak_strength, .gain_cut, .sel_strength);
  rsg_host u_rsg_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  // 100 ns clock
  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  task give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // register read compared against its expectation
  task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    u_rsg_host.rd(a, rd_val);
    chk(nm, e, rd_val);
  endtask : rdc

  // ladders settle through the synchroniser within the fixed latency
  task lad(input logic [13:0] am, input logic [13:0] pm);
    @(posedge sys_clk);
    am_level_thermo <= am;
    pm_level_thermo <= pm;
    repeat (8) @(posedge sys_clk);
  endtask : lad

  // one-cycle event: 0 message start, 1 clear command, 2 defaults
  task pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: msg_start <= 1'h1;
      1: clear_strength_cmd <= 1'h1;
      default: set_default_cmd <= 1'h1;
    endcase
    @(posedge sys_clk);
    {msg_start, clear_strength_cmd, set_default_cmd} <= 3'h0;
  endtask : pulse

  task gains(input logic [7:0] c, input logic [7:0] s, input logic [7:0] a);
    @(posedge sys_clk);
    cfg_gain_cut <= c;
    squelch_gain_cut <= s;
    agc_gain_cut <= a;
    repeat (3) @(posedge sys_clk);
  endtask : gains

  // hang guard, far beyond the fewer than 200 cycles the sequence needs
  initial
  begin
    #2000000;
    n_fail++;
    give_verdict;
  end

  // ===========================================================================
  // sequence
  initial
  begin
    {rst, msg_start, clear_strength_cmd, set_default_cmd, chan_select} = 5'h10;
    {am_level_thermo, pm_level_thermo} = 28'h0;
    {cfg_gain_cut, squelch_gain_cut, agc_gain_cut} = 24'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    rdc(8'h2C, 8'h00, "peak after reset");
    rdc(8'h2D, 8'h00, "gain after reset");
    rdc(8'h2E, 8'h00, "unmapped read");
    gains(8'h21, 8'h12, 8'h13);
    rdc(8'h2D, 8'h46, "gain sum");
    gains(8'hA1, 8'h90, 8'h02);
    rdc(8'h2D, 8'hF3, "gain saturated am");
    lad(14'h007F, 14'h0003);
    rdc(8'h2C, 8'h72, "peak codes");
    lad(14'h0001, 14'h0000);
    rdc(8'h2C, 8'h72, "peak held");
    lad(14'h3FFF, 14'h0007);
    rdc(8'h2C, 8'hE3, "full ladder");
    u_rsg_host.wr(8'h2C, 8'h5A);
    rdc(8'h2C, 8'hE3, "after write");
    rdc(8'h2E, 8'h00, "unmapped read loaded");
    @(posedge sys_clk);
    chan_select <= 1'h1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("selected pm", 8'h03, {4'h0, sel_strength});
    @(posedge sys_clk);
    chan_select <= 1'h0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("selected am", 8'h0E, {4'h0, sel_strength});
    lad(14'h0000, 14'h0000);
    pulse(1);
    rdc(8'h2C, 8'h00, "clear command");
    lad(14'h0003, 14'h0001);
    rdc(8'h2C, 8'h21, "rise after clear");
    lad(14'h0000, 14'h0000);
    pulse(0);
    rdc(8'h2C, 8'h00, "message start");
    lad(14'h0003, 14'h0001);
    lad(14'h0000, 14'h0000);
    pulse(2);
    rdc(8'h2C, 8'h00, "defaults restored");
    give_verdict;
  end
endmodule : rsg_top_test

`default_nettype wire
